// *** inc/dac_ctrl_pkg.sv ***
// Shared constants and types for the serial load and clear controller of a 12-bit converter.
// Assumes one system clock domain and one serial link clock domain supplied by the host.
package dac_ctrl_pkg;

	// Frame and register widths.
	localparam int         WORD_BITS    = 16;
	localparam int         DAC_BITS     = 12;
	localparam int         CTRL_BITS    = 8;
	localparam int         CNT_BITS     = 5;
	localparam logic [4:0] FRAME_LAST   = 5'h0f;
	localparam logic [4:0] FRAME_DONE   = 5'h10;
	localparam logic [3:0] BIT_TOP      = 4'hf;

	// Reset values.
	localparam logic [11:0] DAC_RST     = 12'h000;
	localparam logic [7:0]  CTRL_RST    = 8'h40;
	localparam logic [15:0] WORD_RST    = 16'h0000;

	// Control register fields.
	localparam int CTRL_PWR_BIT = 2;
	localparam int CTRL_HIZ_BIT = 6;

	// Command word layout and addresses.
	localparam logic [2:0] ADDR_DAC  = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h2;

	// Timing and thresholds.
	localparam int TEMP_LIMIT_C = 110;
	localparam int CLK_HZ       = 10_000_000;
	localparam int POR_TIME_US  = 50;
	localparam int POR_CYCLES   = POR_TIME_US * (CLK_HZ / 1_000_000);

	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_ON  = 2'b01,
		PWR_HOT = 2'b11
	} pwr_state_type;

	typedef struct packed {
		logic        read;
		logic [2:0]  addr;
		logic [11:0] data;
	} frame_type;

	typedef struct packed {
		logic clear_n;
		logic load_n;
		logic die_hot;
		logic range_n;
		logic wr_tog;
	} pins_type;

	localparam pins_type PINS_RST = '{clear_n: 1'b1, load_n: 1'b1, die_hot: 1'b0, range_n: 1'b1, wr_tog: 1'b0};

	typedef struct packed {
		logic amp_on;
		logic out_hiz;
		logic out_gnd;
		logic range_wide;
	} analog_type;

	localparam analog_type ANALOG_RST = '{amp_on: 1'b0, out_hiz: 1'b1, out_gnd: 1'b0, range_wide: 1'b0};

endpackage : dac_ctrl_pkg

// *** verification/dac_ctrl_props.sv ***
// Concurrent checks on the ports of the converter controller.
// Assumes clk runs free and rst_n is asynchronous, active low.
`timescale 1ns/1ps
module dac_ctrl_props
	import dac_ctrl_pkg::*;
(
	input wire logic                             clk,           // system clock
	input wire logic                             rst_n,         // reset, active low
	input wire logic                             sclk,          // link clock
	input wire logic                             frame_n,       // frame select
	input wire logic                             sdi,           // serial in
	input wire logic                             sdo,           // serial out
	input wire logic                             async_clear_n, // clear pin
	input wire logic                             load_output_n, // load pin
	input wire logic                             die_hot,       // comparator
	input wire logic                             range_sel_n,   // range pin
	input wire logic [dac_ctrl_pkg::DAC_BITS-1:0] dac_code,      // converter register
	input wire dac_ctrl_pkg::analog_type          analog,        // analog controls
	input wire logic                             alarm_n        // temperature flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence clear_hit;
		$fell(async_clear_n);
	endsequence

	sequence hot_held;
		!alarm_n [*3];
	endsequence

	clear_zero_a: assert property (clear_hit |-> ##[1:5] dac_code == 12'h000)
		else $error("converter not cleared");
	clear_block_a: assert property (!async_clear_n [*6] |-> $stable(dac_code))
		else $error("converter moved while clear low");
	alarm_flag_a: assert property ($stable(die_hot) [*4] |-> alarm_n == !die_hot)
		else $error("temperature flag wrong");
	range_pick_a: assert property ($stable(range_sel_n) [*4] |-> analog.range_wide == !range_sel_n)
		else $error("range select wrong");
	thermal_off_a: assert property ($fell(alarm_n) |-> ##[0:2] (analog.out_hiz && !analog.amp_on))
		else $error("no thermal power-down");
	hot_hold_a: assert property (hot_held |-> analog.out_hiz && !analog.amp_on)
		else $error("output live while hot");
	power_gate_a: assert property ($rose(analog.amp_on) |-> alarm_n)
		else $error("power-up while alarmed");
	sdo_idle_a: assert property (frame_n [*2] |-> !sdo)
		else $error("serial out busy outside frame");
	reset_state_a: assert property ($rose(rst_n) |-> dac_code == DAC_RST && analog == ANALOG_RST && alarm_n)
		else $error("reset state wrong");
endmodule : dac_ctrl_props

bind dac_serial_load_clear_ctrl dac_ctrl_props props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .frame_n(frame_n),
	.sdi(sdi), .sdo(sdo), .async_clear_n(async_clear_n), .load_output_n(load_output_n), .die_hot(die_hot),
	.range_sel_n(range_sel_n), .dac_code(dac_code), .analog(analog), .alarm_n(alarm_n));

// *** verification/dac_serial_load_clear_ctrl_test.sv ***
// Self-checking bench for the converter controller with a behavioural serial host.
// Assumes the design answers a frame within a few clk cycles.
`timescale 1ns/1ps
module dac_serial_load_clear_ctrl_test;
	import dac_ctrl_pkg::*;
	typedef struct packed {logic load_n; logic [15:0] word; logic [11:0] exp;} row_type;
	logic clk, rst_n, sclk, frame_n, sdi, sdo, async_clear_n, load_output_n, die_hot, range_sel_n, alarm_n;
	logic [DAC_BITS-1:0] dac_code;
	analog_type          analog;
	logic [15:0]         got;
	int                  miscompares = 0;
	int                  comparisons = 0;
	row_type rows [4] = '{'{1'b0, 16'h1abc, 12'habc}, '{1'b0, 16'h1fff, 12'hfff},
		'{1'b1, 16'h1123, 12'hfff}, '{1'b1, 16'h3555, 12'hfff}};

	dac_serial_load_clear_ctrl dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .frame_n(frame_n), .sdi(sdi),
		.sdo(sdo), .async_clear_n(async_clear_n), .load_output_n(load_output_n), .die_hot(die_hot),
		.range_sel_n(range_sel_n), .dac_code(dac_code), .analog(analog), .alarm_n(alarm_n));
	serial_host host (.sclk(sclk), .frame_n(frame_n), .sdi(sdi), .sdo(sdo));

	always #50 clk = ~clk;

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk

	task automatic check(input logic [15:0] val, input logic [15:0] exp);
		comparisons++;
		if (val !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, val, exp);
		end
	endtask : check

	task automatic frame(input logic [15:0] word, input int edges);
		wait_clk(8);
		host.xfer(word, edges, got);
		wait_clk(8);
	endtask : frame

	task automatic pulse_load();
		load_output_n = 1'b0;
		wait_clk(3);
		load_output_n = 1'b1;
		wait_clk(8);
	endtask : pulse_load

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#2_000_000;
		miscompares++;
		print_verdict();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		async_clear_n = 1'b1;
		load_output_n = 1'b1;
		die_hot = 1'b0;
		range_sel_n = 1'b1;
		wait_clk(5);
		rst_n = 1'b1;
		check({4'h0, dac_code}, 16'h0000);
		check({12'h0, analog}, {12'h0, ANALOG_RST});
		wait_clk(POR_CYCLES);
		frame(16'ha000, 16);
		frame(16'h0000, 16);
		check(got, 16'h0040);
		foreach (rows[i]) begin
			load_output_n = rows[i].load_n;
			frame(rows[i].word, 16);
			check({4'h0, dac_code}, {4'h0, rows[i].exp});
		end
		pulse_load();
		check({4'h0, dac_code}, 16'h0123);
		frame(16'h1777, 15);
		pulse_load();
		check({4'h0, dac_code}, 16'h0123);
		load_output_n = 1'b0;
		frame(16'h1456, 18);
		check({4'h0, dac_code}, 16'h0456);
		frame(16'h9000, 16);
		frame(16'h0000, 16);
		check(got, 16'h0456);
		load_output_n = 1'b1;
		async_clear_n = 1'b0;
		wait_clk(8);
		check({4'h0, dac_code}, 16'h0000);
		frame(16'h1321, 16);
		pulse_load();
		check({4'h0, dac_code}, 16'h0000);
		async_clear_n = 1'b1;
		for (int i = 0; i < 2; i++) begin
			range_sel_n = i[0];
			wait_clk(6);
			check({15'h0, analog.range_wide}, {15'h0, ~i[0]});
		end
		frame(16'h2004, 16);
		check({14'h0, analog.out_hiz, analog.amp_on}, 16'h0001);
		die_hot = 1'b1;
		wait_clk(6);
		check({15'h0, alarm_n}, 16'h0000);
		check({14'h0, analog.out_hiz, analog.amp_on}, 16'h0002);
		die_hot = 1'b0;
		wait_clk(6);
		check({15'h0, alarm_n}, 16'h0001);
		check({14'h0, analog.out_hiz, analog.amp_on}, 16'h0002);
		frame(16'h2004, 16);
		check({14'h0, analog.out_hiz, analog.amp_on}, 16'h0001);
		frame(16'h2000, 16);
		check({12'h0, analog}, 16'h0002);
		pulse_load();
		check({4'h0, dac_code}, 16'h0321);
		rst_n = 1'b0;
		wait_clk(5);
		check({4'h0, dac_code}, 16'h0000);
		check({12'h0, analog}, {12'h0, ANALOG_RST});
		check({15'h0, alarm_n}, 16'h0001);
		rst_n = 1'b1;
		wait_clk(POR_CYCLES);
		frame(16'ha000, 16);
		frame(16'h0000, 16);
		check(got, 16'h0040);
		print_verdict();
	end
endmodule : dac_serial_load_clear_ctrl_test

// *** verification/serial_host.sv ***
// Behavioural serial master that frames 16-bit words to the converter.
// Assumes the caller spaces frames; its clock idles low outside frames.
`timescale 1ns/1ps
module serial_host (
	output logic      sclk,    // link clock, 32 ns period
	output logic      frame_n, // frame select, active low
	output logic      sdi,     // serial data to the device
	input  wire logic sdo      // serial data from the device
);
	initial begin
		sclk = 1'b0;
		frame_n = 1'b1;
		sdi = 1'b0;
	end

	task automatic xfer(input logic [15:0] word, input int edges, output logic [15:0] got);
		got = 16'h0000;
		#7 frame_n = 1'b0;
		for (int i = 0; i < edges; i++) begin
			#2 sdi = (i < 16) ? word[15 - i] : ~sdi;
			#14 sclk = 1'b1;
			#16 sclk = 1'b0;
			got = {got[14:0], sdo};
		end
		#8 frame_n = 1'b1;
		sdi = ~sdi;
	endtask : xfer
endmodule : serial_host

// *** verilog/bit_sync.sv ***
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a level that stays put for at least two destination clock periods.
`timescale 1ns/1ps
module bit_sync #(
	parameter int                 WIDTH   = 1,
	parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
	input  wire logic             clk,     // destination clock
	input  wire logic             rst_n,   // asynchronous reset, active low
	input  wire logic [WIDTH-1:0] din,     // asynchronous levels
	output logic      [WIDTH-1:0] dout     // synchronised levels
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule : bit_sync

// *** verilog/dac_serial_load_clear_ctrl.sv ***
// Serial load and clear controller for a single 12-bit voltage-output converter.
// Assumes a host drives sclk, frame_n and sdi, and that clk runs free from reset onward.
// Functional notes
// - A falling frame select opens the 16-bit shift register, which takes bits only while frame select is low.
// - Each serial bit is shifted in on the falling edge of the serial clock.
// - The addressed register is updated on the third rising clk edge after the 16th falling serial clock edge of the frame.
// - A frame select that rises before the 16th falling edge aborts the frame and changes nothing.
// - A falling edge on the clear input forces the input and converter registers to zero.
// - While the clear input is low every load pulse is ignored.
// - A low pulse on the load input copies the input register into the converter register.
// - With the load input held low and the clear input high, each completed converter register write also updates the converter register.
// - Readback bits are launched on rising serial clock edges for the host to take on falling edges.
// - The over-temperature flag output is driven low whenever the die is above its limit.
// - A low range select picks the wide output range and a high one the narrow range.
// - After reset the control register holds 0x40 and the input and converter registers hold zero.
// - Over-temperature forces a thermal power-down with a floating output until a software power-up.
`timescale 1ns/1ps
module dac_serial_load_clear_ctrl (
	input  wire logic                          clk,            // system clock, 10 MHz
	input  wire logic                          rst_n,          // power-on reset, active low
	input  wire logic                          sclk,           // serial link clock from the host
	input  wire logic                          frame_n,        // frame select, active low
	input  wire logic                          sdi,            // serial data in
	output logic                               sdo,            // serial data out
	input  wire logic                          async_clear_n,  // clear pin, falling edge acts
	input  wire logic                          load_output_n,  // load pin, active low
	input  wire logic                          die_hot,        // temperature comparator, high when too hot
	input  wire logic                          range_sel_n,    // range select pin
	output logic      [dac_ctrl_pkg::DAC_BITS-1:0] dac_code,   // converter register
	output dac_ctrl_pkg::analog_type           analog,         // analog section controls
	output logic                               alarm_n         // over-temperature flag, active low
);
	import dac_ctrl_pkg::*;

	// Link side state, clocked by sclk.
	logic                  frame_rst_n;
	logic [CNT_BITS-1:0]   bit_cnt_q;
	logic [WORD_BITS-1:0]  shift_q;
	logic [WORD_BITS-1:0]  wr_word_q;
	logic                  wr_tog_q;
	logic                  sdo_q;
	logic [3:0]            sdo_idx;

	// System side state, clocked by clk.
	pins_type              pins_raw;
	pins_type              pins_s;
	logic                  clear_fall;
	logic                  load_fall;
	logic                  tog_rise;
	logic                  tog_fall;
	logic                  wr_done;
	frame_type             cmd;
	logic                  dac_wr;
	logic                  ctrl_wr;
	logic                  rd_req;
	logic [DAC_BITS-1:0]   input_q;
	logic [DAC_BITS-1:0]   dac_q;
	logic [CTRL_BITS-1:0]  ctrl_q;
	logic [WORD_BITS-1:0]  rd_word_q;
	logic [WORD_BITS-1:0]  rd_word_d;
	logic [WORD_BITS-1:0]  sdo_word_q;
	logic                  frame_idle;
	pwr_state_type         state_q;
	pwr_state_type         state_d;
	analog_type            analog_q;
	analog_type            analog_d;
	logic                  alarm_n_q;

	// The frame select high holds the link counter and readback driver in reset,
	// so an aborted frame ends even when sclk stops.
	assign frame_rst_n = rst_n & ~frame_n;

	always_ff @(negedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_q <= '0;
			shift_q   <= WORD_RST;
		end else if (bit_cnt_q < FRAME_DONE) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			shift_q   <= {shift_q[WORD_BITS-2:0], sdi};
		end
	end

	// The completed word stays stable until the next full frame, which is what makes
	// it safe to read from the clk domain once the toggle has been synchronised.
	// update on 16th edge
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_word_q <= WORD_RST;
			wr_tog_q  <= 1'b0;
		end else if (!frame_n && bit_cnt_q == FRAME_LAST) begin
			wr_word_q <= {shift_q[WORD_BITS-2:0], sdi};
			wr_tog_q  <= ~wr_tog_q;
		end
	end

	assign sdo_idx = BIT_TOP - bit_cnt_q[3:0];

	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			sdo_q <= 1'b0;
		end else if (bit_cnt_q < FRAME_DONE) begin
			sdo_q <= sdo_word_q[sdo_idx];
		end else begin
			sdo_q <= 1'b0;
		end
	end

	assign sdo = sdo_q;

	// The clear, load, temperature and range pins and the write toggle cross into clk through two flip-flops.
	assign pins_raw = '{clear_n: async_clear_n, load_n: load_output_n, die_hot: die_hot,
		range_n: range_sel_n, wr_tog: wr_tog_q};

	bit_sync #(
		.WIDTH   ($bits(pins_type)),
		.RST_VAL (PINS_RST)
	) u_pin_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (pins_raw),
		.dout  (pins_s)
	);

	edge_detect #(
		.RST_VAL (1'b1)
	) u_clear_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.level (pins_s.clear_n),
		.rise  (),
		.fall  (clear_fall)
	);

	edge_detect #(
		.RST_VAL (1'b1)
	) u_load_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.level (pins_s.load_n),
		.rise  (),
		.fall  (load_fall)
	);

	edge_detect #(
		.RST_VAL (1'b0)
	) u_tog_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.level (pins_s.wr_tog),
		.rise  (tog_rise),
		.fall  (tog_fall)
	);

	// Each toggle change marks one completed frame.
	assign wr_done = tog_rise | tog_fall;
	assign cmd     = frame_type'(wr_word_q);

	always_comb begin
		dac_wr  = 1'b0;
		ctrl_wr = 1'b0;
		rd_req  = 1'b0;
		if (wr_done) begin
			if (cmd.read) begin
				rd_req = 1'b1;
			end else if (cmd.addr == ADDR_DAC) begin
				dac_wr = 1'b1;
			end else if (cmd.addr == ADDR_CTRL) begin
				ctrl_wr = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			input_q <= DAC_RST;
		end else if (clear_fall) begin
			input_q <= DAC_RST;
		end else if (dac_wr) begin
			input_q <= cmd.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_q <= DAC_RST;
		end else if (clear_fall) begin
			dac_q <= DAC_RST;
		end else if (!pins_s.clear_n) begin
			dac_q <= dac_q;
		end else if (dac_wr && !pins_s.load_n) begin
			// held load auto-updates
			// A write that completes as the load pin falls carries the newer data, so it wins.
			dac_q <= cmd.data;
		end else if (load_fall) begin
			dac_q <= input_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_q <= cmd.data[CTRL_BITS-1:0];
		end
	end

	// A read frame selects what the next frame shifts out.
	always_comb begin
		rd_word_d = rd_word_q;
		if (rd_req) begin
			case (cmd.addr)
				ADDR_DAC: begin
					rd_word_d = {4'h0, dac_q};
				end
				ADDR_CTRL: begin
					rd_word_d = {8'h00, ctrl_q};
				end
				default: begin
					rd_word_d = WORD_RST;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_word_q <= WORD_RST;
		end else begin
			rd_word_q <= rd_word_d;
		end
	end

	// Frame select crosses into clk so that the readback word only moves between frames.
	bit_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_frame_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (frame_n),
		.dout  (frame_idle)
	);

	// The link reads this word bit by bit without a handshake of its own; holding it still while
	// a frame is open keeps a late read answer from mixing two words. The frame spacing gives
	// the two-cycle lag of the synchroniser room to settle before the next frame.
	// stable readback word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_word_q <= WORD_RST;
		end else if (frame_idle) begin
			sdo_word_q <= rd_word_q;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			PWR_OFF: begin
				if (ctrl_q[CTRL_PWR_BIT]) begin
					state_d = PWR_ON;
				end
			end
			PWR_ON: begin
				if (!ctrl_q[CTRL_PWR_BIT]) begin
					state_d = PWR_OFF;
				end
			end
			PWR_HOT: begin
				if (ctrl_wr && cmd.data[CTRL_PWR_BIT]) begin
					state_d = PWR_ON;
				end
			end
			default: begin
				state_d = PWR_OFF;
			end
		endcase
		// An over-temperature in the same cycle as a power-up command wins.
		if (pins_s.die_hot) begin
			state_d = PWR_HOT;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PWR_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	always_comb begin
		analog_d            = ANALOG_RST;
		analog_d.amp_on     = (state_q == PWR_ON);
		analog_d.out_hiz    = (state_q == PWR_HOT) || (state_q == PWR_OFF && ctrl_q[CTRL_HIZ_BIT]);
		analog_d.out_gnd    = (state_q == PWR_OFF) && !ctrl_q[CTRL_HIZ_BIT];
		analog_d.range_wide = ~pins_s.range_n;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_q <= ANALOG_RST;
		end else begin
			analog_q <= analog_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_n_q <= 1'b1;
		end else begin
			alarm_n_q <= ~pins_s.die_hot;
		end
	end

	assign dac_code = dac_q;
	assign analog   = analog_q;
	assign alarm_n  = alarm_n_q;

endmodule : dac_serial_load_clear_ctrl

// *** verilog/edge_detect.sv ***
// Edge detector for a level that is already synchronous to clk.
// Assumes the input comes from a synchroniser output, never from its first stage.
`timescale 1ns/1ps
module edge_detect #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,     // system clock
	input  wire logic rst_n,   // asynchronous reset, active low
	input  wire logic level,   // synchronous level
	output logic      rise,    // one-cycle pulse on a rising edge
	output logic      fall     // one-cycle pulse on a falling edge
);

	logic prev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= RST_VAL;
		end else begin
			prev_q <= level;
		end
	end

	assign rise = level & ~prev_q;
	assign fall = ~level & prev_q;

endmodule : edge_detect
